/* File: audio_channel_out.sv */
// one audio channel: dma or direct sample feed into the converter
`timescale 1ns/1ps
`default_nettype none
`include "audio_out_map.svh"
// Overview of operation
// - single buffer reloads pointers automatically, loops
// - dma interrupt on each restart at buffer top
// - dma start copies length, location, then fetches
// - direct mode plays written word's two bytes
// - dma interrupt after location loaded, not per word
// - direct interrupt after each word fully output
// - direct starved two intervals: output stops updating
// - starved output holds last sample indefinitely
// - volume and period apply in both modes
// - control bit selects filter bypass and indicator
module audio_channel_out
  import audio_out_pkg::*;
#(
  parameter int AW = `ADDR_W,
  parameter int LW = `LEN_W,
  parameter int PW = `PER_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic dma_en,
  input wire logic [AW-1:0] location,
  input wire logic [LW-1:0] length,
  input wire logic [PW-1:0] period,
  input wire logic [`VOL_W-1:0] volume,
  input wire logic dma_slot,
  output logic dma_req,
  output logic [AW-1:0] dma_addr,
  input wire logic dma_ack,
  input wire logic [15:0] dma_data,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_data,
  input wire logic port_bit_in,
  output logic [7:0] dac_sample,
  output logic [`VOL_W-1:0] dac_volume,
  output logic filter_bypass,
  output logic filter_bypass_indicator_bit,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dma_state_t st_ff, nxt_st;
  logic [AW-1:0] ptr_ff, nxt_ptr;
  logic [LW-1:0] left_ff, nxt_left;
  logic [15:0] word_ff, nxt_word;
  logic word_ok_ff, nxt_word_ok;
  logic half_ff, nxt_half;
  logic [1:0] starve_ff, nxt_starve;
  logic [7:0] samp_ff, nxt_samp;
  logic irq_ff, nxt_irq;
  // two stages: the port bit comes from another device's clock
  logic bypass_meta_ff, nxt_bypass_meta;
  logic bypass_ff, nxt_bypass;
  logic [`VOL_W-1:0] vol_ff, nxt_vol;
  logic tick;
  logic run;

  // ------------------------------------------------------------
  // byte select
  // ------------------------------------------------------------
  // high byte goes out first, then the low byte of the same word
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic low);
    logic [7:0] b;
    if (low) begin
      b = w[7:0];
    end else begin
      b = w[15:8];
    end
    return b;
  endfunction

  // ------------------------------------------------------------
  // sample timer
  // ------------------------------------------------------------
  // the timer keeps counting through a fetch so the interval does not stretch
  assign run = dma_en ? (st_ff == ST_RUN || st_ff == ST_FETCH) : 1'b1;

  sample_timer #(.PW(PW)) u_timer (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(run),
    .period(period),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_ptr = ptr_ff;
    nxt_left = left_ff;
    nxt_word = word_ff;
    nxt_word_ok = word_ok_ff;
    nxt_half = half_ff;
    nxt_starve = starve_ff;
    nxt_samp = samp_ff;
    nxt_irq = 1'b0;
    nxt_bypass_meta = port_bit_in;
    nxt_bypass = bypass_meta_ff;
    nxt_vol = volume;
    dma_req = 1'b0;
    if (dma_en) begin
      case (st_ff)
        ST_IDLE: begin
          // start is taken one cycle after the enable is seen
          nxt_st = ST_LOAD;
        end
        ST_LOAD: begin
          nxt_ptr = location;
          nxt_left = length;
          // working copies taken: software may now load the next buffer
          nxt_irq = 1'b1;
          nxt_word_ok = 1'b0;
          nxt_st = ST_FETCH;
        end
        ST_FETCH: begin
          // ask only inside an allotted slot; the memory side answers there
          dma_req = dma_slot;
          if (dma_slot && dma_ack) begin
            nxt_word = dma_data;
            nxt_word_ok = 1'b1;
            nxt_half = 1'b0;
            nxt_ptr = ptr_ff + {{(AW-2){1'b0}}, 2'h2};
            // a zero length is taken as one word instead of wrapping round
            nxt_left = (left_ff == '0) ? '0 : left_ff - 1'b1;
            nxt_st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            nxt_samp = pick_byte(word_ff, half_ff);
            nxt_half = ~half_ff;
            if (half_ff) begin
              // last word of the buffer: restart at the top on our own
              nxt_st = (left_ff == '0) ? ST_LOAD : ST_FETCH;
            end
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end else begin
      nxt_st = ST_IDLE;
      // a write wins over a tick in the same cycle; that tick is lost
      if (cpu_wr) begin
        nxt_word = cpu_data;
        nxt_word_ok = 1'b1;
        nxt_half = 1'b0;
        nxt_starve = 2'h0;
      end else if (tick) begin
        if (starve_ff < 2'(`STARVE_INTERVALS)) begin
          // output changes only while fresh bytes remain; else frozen
          if (word_ok_ff) begin
            nxt_samp = pick_byte(word_ff, half_ff);
            nxt_half = ~half_ff;
            if (half_ff) begin
              nxt_irq = 1'b1;
            end
          end
          nxt_starve = starve_ff + 2'h1;
        end
        // starved: samp_ff left untouched
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // ce low freezes every register, the timer's included
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= ST_IDLE;
      ptr_ff <= '0;
      left_ff <= '0;
      word_ff <= 16'h0000;
      word_ok_ff <= 1'b0;
      half_ff <= 1'b0;
      starve_ff <= 2'h0;
      samp_ff <= 8'h00;
      irq_ff <= 1'b0;
      bypass_meta_ff <= 1'b0;
      bypass_ff <= 1'b0;
      vol_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
      ptr_ff <= nxt_ptr;
      left_ff <= nxt_left;
      word_ff <= nxt_word;
      word_ok_ff <= nxt_word_ok;
      half_ff <= nxt_half;
      starve_ff <= nxt_starve;
      samp_ff <= nxt_samp;
      irq_ff <= nxt_irq;
      bypass_meta_ff <= nxt_bypass_meta;
      bypass_ff <= nxt_bypass;
      vol_ff <= nxt_vol;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // volume is registered like the other data outputs, one cycle behind
  assign dma_addr = ptr_ff;
  assign dac_sample = samp_ff;
  assign dac_volume = vol_ff;
  assign filter_bypass = bypass_ff;
  assign filter_bypass_indicator_bit = bypass_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

/* File: audio_out_map.svh */
// offsets-free constants for the audio channel sample output
`ifndef AUDIO_OUT_MAP_SVH
`define AUDIO_OUT_MAP_SVH
`define PER_W 16
`define LEN_W 16
`define ADDR_W 24
`define VOL_W 7
`define STARVE_INTERVALS 2
`define BYPASS_BIT 1
`endif

/* File: audio_out_pkg.sv */
// types for the audio channel sample output
package audio_out_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_RUN   = 4'b1000
  } dma_state_t;
endpackage

/* File: sample_timer.sv */
// period down-counter giving one tick per sampling interval
`timescale 1ns/1ps
`default_nettype none
`include "audio_out_map.svh"
module sample_timer #(
  parameter int PW = `PER_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [PW-1:0] period,
  output logic tick
);
  logic [PW-1:0] cnt_ff;
  logic [PW-1:0] nxt_cnt;
  always_comb begin
    tick = run && (cnt_ff == '0);
    nxt_cnt = cnt_ff;
    if (!run) begin
      nxt_cnt = '0;
    end else if (cnt_ff == '0) begin
      // a zero period still gives a tick every cycle rather than wrapping
      nxt_cnt = (period == '0) ? '0 : period - 1'b1;
    end else begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

/* File: audio_chk.sv */
// port checker for the audio channel
`timescale 1ns/1ps
`default_nettype none
module audio_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dma_en,
  input wire logic cpu_wr,
  input wire logic dma_slot,
  input wire logic dma_req,
  input wire logic irq,
  input wire logic port_bit_in,
  input wire logic filter_bypass,
  input wire logic filter_bypass_indicator_bit,
  input wire logic [6:0] volume,
  input wire logic [6:0] dac_volume,
  input wire logic [7:0] dac_sample
);
  // output changes since the last direct write; hi and lo bytes allow two
  logic [1:0] chg_ff;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) chg_ff <= 2'h0;
    else chg_ff <= (dma_en || cpu_wr) ? 2'h0 : chg_ff + 2'(chg_ff != 2'h3 && $changed(dac_sample));
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_bypass_lag: assert property (1 |=> filter_bypass == $past(port_bit_in, 2)) else $error("bypass");
  chk_led_same: assert property (filter_bypass_indicator_bit == filter_bypass) else $error("led");
  chk_vol_pass: assert property (1 |=> dac_volume == $past(volume)) else $error("volume");
  chk_req_slot: assert property (dma_req |-> dma_slot) else $error("req");
  chk_irq_pulse: assert property (irq |=> !irq) else $error("irq long");
  chk_load_irq: assert property ($rose(dma_en) |-> ##2 irq) else $error("load irq");
  chk_starve_hold: assert property (chg_ff != 2'h3) else $error("starve");
  chk_direct_noreq: assert property (!dma_en [*3] |-> !dma_req) else $error("fetch");
endmodule
bind audio_channel_out audio_chk u_chk (.clk, .resetn, .dma_en, .cpu_wr, .dma_slot, .dma_req, .irq,
  .port_bit_in, .filter_bypass, .filter_bypass_indicator_bit, .volume, .dac_volume, .dac_sample);
`default_nettype wire

/* File: mem_side.sv */
// memory side model answering channel fetches
`timescale 1ns/1ps
`default_nettype none
module mem_side (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dma_req,
  input wire logic [23:0] dma_addr,
  output logic dma_slot,
  output logic dma_ack,
  output logic [15:0] dma_data
);
  logic [15:0] word;
  // slots on alternate cycles only, so the channel must wait for them
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) dma_slot <= 1'b0;
    else dma_slot <= !dma_slot;
  assign word = {dma_addr[7:0], ~dma_addr[7:0]};
  assign dma_ack = dma_req;
  // bus not acknowledged shows inverted data, never the last word
  assign dma_data = dma_ack ? word : ~word;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the audio channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, resetn, dma_en, dma_slot, dma_req, dma_ack, cpu_wr, port_bit_in, filter_bypass, irq;
  logic [23:0] dma_addr;
  logic [15:0] cpu_data, dma_data;
  logic [7:0] dac_sample;
  logic [6:0] dac_volume;
  int errors = 0;
  int compares = 0;
  // period inside the advised full-bandwidth span
  localparam int PER_CYC = 124;
  localparam int WAIT_MAX = 400;
  audio_channel_out u_dut (.clk, .resetn, .ce(1'b1), .dma_en, .location(24'h000140), .length(16'h0002),
    .period(16'(PER_CYC)), .volume(7'h2a), .dma_slot, .dma_req, .dma_addr, .dma_ack, .dma_data, .cpu_wr,
    .cpu_data, .port_bit_in, .dac_sample, .dac_volume, .filter_bypass, .filter_bypass_indicator_bit(), .irq);
  mem_side u_mem (.clk, .resetn, .dma_req, .dma_addr, .dma_slot, .dma_ack, .dma_data);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic wait_smp(logic [7:0] exp);
    for (int n = 0; n < WAIT_MAX && dac_sample !== exp; n++) @(negedge clk);
    cmp(dac_sample, exp);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < WAIT_MAX && irq !== 1'b1; n++) @(negedge clk);
    cmp({7'h00, irq}, 8'h01);
    @(negedge clk);
  endtask
  task automatic write_word(logic [15:0] d);
    @(posedge clk);
    cpu_data <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic bypass_sel();
    @(negedge clk);
    cmp({7'h00, filter_bypass}, 8'h00);
    @(posedge clk);
    port_bit_in <= 1'b1;
    repeat (3) @(negedge clk);
    cmp({7'h00, filter_bypass}, 8'h01);
  endtask
  task automatic direct_play();
    logic [15:0] gap = 16'h0000;
    logic [15:0] moved = 16'h0000;
    write_word(16'h7f80);
    wait_smp(8'h7f);
    while (dac_sample !== 8'h80 && gap < WAIT_MAX) begin
      @(negedge clk);
      gap++;
    end
    cmp(dac_sample, 8'h80);
    cmp_cnt(gap, 16'(PER_CYC));
    wait_irq();
    // three whole intervals: a missing freeze would replay the high byte
    for (int n = 0; n < 3 * PER_CYC; n++) begin
      @(negedge clk);
      if (dac_sample !== 8'h80) moved++;
    end
    cmp_cnt(moved, 16'h0000);
    cmp(dac_sample, 8'h80);
    cmp({1'b0, dac_volume}, 8'h2a);
    write_word(16'h1234);
    wait_smp(8'h12);
    wait_smp(8'h34);
  endtask
  task automatic dma_loop();
    @(posedge clk);
    dma_en <= 1'b1;
    wait_irq();
    wait_smp(8'h40);
    wait_smp(8'hbf);
    wait_smp(8'h42);
    wait_irq();
    wait_smp(8'h40);
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    dma_en = 1'b0;
    cpu_wr = 1'b0;
    cpu_data = 16'h0000;
    port_bit_in = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    bypass_sel();
    direct_play();
    dma_loop();
    end_sim();
  end
  // about fifteen hundred cycles are expected; this cuts a hang
  initial begin
    #60000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
